//--- pkg/tsip_pkg.sv
// constants and types for the two-wire temperature sensor host controller
package tsip_pkg;

  // system clock and bus timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_LOW_NS      = 1300;
  localparam int T_HIGH_NS     = 600;
  localparam int T_BUF_NS      = 1300;
  // one quarter of a bit time; two quarters low and two high cover every minimum
  localparam int T_QTR_CYC_I   = (T_LOW_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] T_QTR_CYC  = T_QTR_CYC_I[7:0];
  localparam logic [8:0] T_LOW_CYC  = 9'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] Q_LAST_BIT  = 3'h3;
  localparam logic [2:0] Q_LAST_STOP = 3'h5;

  // slave address byte layout
  localparam logic [3:0] ADDR_FIXED = 4'h9;
  localparam int         ADDR_SEL_W = 3;

  // pointer register
  localparam int         PTR_W     = 2;
  localparam logic [1:0] PTR_TEMP  = 2'h0;
  localparam logic [1:0] PTR_CONFIGURATION_BYTE  = 2'h1;
  localparam logic [1:0] PTR_HYST  = 2'h2;
  localparam logic [1:0] PTR_TRIP  = 2'h3;
  localparam logic [5:0] PTR_PAD   = 6'h00;

  // device power-up contents
  localparam logic [7:0]  CONFIGURATION_BYTE_RESET = 8'h00;
  localparam logic [15:0] HYST_RESET = 16'h4b00;
  localparam logic [15:0] TRIP_RESET = 16'h5000;
  localparam logic [1:0]  PTR_RESET  = PTR_TEMP;

  // byte framing
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [1:0] LEN_NONE  = 2'h0;
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;

  typedef enum logic [1:0] {TSIP_CMD_START, TSIP_CMD_STOP, TSIP_CMD_WRITE, TSIP_CMD_READ} tsip_cmd_type;
  typedef enum {S_IDLE, S_START, S_TX, S_RX, S_STOP} tsip_state_type;
  typedef enum {STG_ADDR_W, STG_PTR, STG_WDATA, STG_ADDR_R, STG_RDATA} tsip_stage_type;

endpackage

//--- pkg/tsip_bit_if.sv
// bit-level command channel between the transaction sequencer and the pin engine
`timescale 1ns/100ps
interface tsip_bit_if;
  import tsip_pkg::*;
  tsip_cmd_type cmd;
  logic         cmd_valid;
  logic         cmd_ready;
  logic         wbit;
  logic         done;
  logic         rbit;
  modport engine (input cmd, cmd_valid, wbit, output cmd_ready, done, rbit);
  modport ctrl   (output cmd, cmd_valid, wbit, input cmd_ready, done, rbit);
endinterface

//--- hw/tsip_bit_engine.sv
// pin engine: clock generation, start/stop/bit shaping on the open-drain lines
`timescale 1ns/100ps
module tsip_bit_engine (
  // system
  input  wire logic  clk_sys,
  input  wire logic  rst,
  // command channel
  tsip_bit_if.engine bif,
  // clock line
  input  wire logic  scl_i,
  output logic       scl_o,
  output logic       scl_oe,
  // data line
  input  wire logic  sda_i,
  output logic       sda_o,
  output logic       sda_oe
);
  import tsip_pkg::*;

  logic [1:0]   scl_sync_r;
  logic [1:0]   sda_sync_r;
  logic         busy_r;
  logic         in_xfer_r;
  logic         scl_low_r;
  logic         sda_low_r;
  logic         wbit_r;
  logic         rbit_r;
  logic         done_r;
  logic [2:0]   q_r;
  logic [7:0]   tick_r;
  logic [8:0]   low_cnt_r;
  tsip_cmd_type cur_r;

  wire scl_s     = scl_sync_r[1];
  wire sda_s     = sda_sync_r[1];
  wire bus_free  = scl_s & sda_s;
  // a slave holding the clock low stalls the quarter timer
  wire stretched = ~scl_low_r & ~scl_s;
  wire tick_end  = (tick_r == T_QTR_CYC - 8'h01) & ~stretched;
  wire last_q    = (q_r == ((cur_r == TSIP_CMD_STOP) ? Q_LAST_STOP : Q_LAST_BIT));
  wire accept    = bif.cmd_valid & bif.cmd_ready;
  wire is_start  = (cur_r == TSIP_CMD_START);
  wire is_stop   = (cur_r == TSIP_CMD_STOP);

  // fresh start only onto an idle bus; repeated start inside a transfer
  assign bif.cmd_ready = ~busy_r & ((bif.cmd != TSIP_CMD_START) | in_xfer_r | bus_free);
  assign bif.done      = done_r;
  assign bif.rbit      = rbit_r;
  // lines are only ever pulled low; pull-ups give the high level
  assign scl_o  = 1'b0;
  assign scl_oe = scl_low_r;
  assign sda_o  = 1'b0;
  assign sda_oe = sda_low_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_r    <= 1'b0;
      in_xfer_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      wbit_r    <= 1'b0;
      rbit_r    <= 1'b0;
      done_r    <= 1'b0;
      q_r       <= 3'h0;
      tick_r    <= 8'h00;
      cur_r     <= TSIP_CMD_STOP;
    end else begin
      done_r <= 1'b0;
      if (accept) begin
        busy_r    <= 1'b1;
        cur_r     <= bif.cmd;
        wbit_r    <= bif.wbit;
        q_r       <= 3'h0;
        tick_r    <= 8'h00;
        scl_low_r <= 1'b1;
      end else if (busy_r && !tick_end) begin
        tick_r <= tick_r + (stretched ? 8'h00 : 8'h01);
      end else if (busy_r && last_q) begin
        busy_r    <= 1'b0;
        done_r    <= 1'b1;
        rbit_r    <= sda_s; // sampled at the end of the high phase
        in_xfer_r <= is_start ? 1'b1 : (is_stop ? 1'b0 : in_xfer_r);
      end else if (busy_r) begin
        q_r    <= q_r + 3'h1;
        tick_r <= 8'h00;
        unique case (q_r)
          3'h0: sda_low_r <= is_stop | ((cur_r == TSIP_CMD_WRITE) & ~wbit_r);
          3'h1: scl_low_r <= 1'b0;
          3'h2: sda_low_r <= is_start ? 1'b1 : (is_stop ? 1'b0 : sda_low_r);
          default: sda_low_r <= sda_low_r;
        endcase
      end
    end
  end

  // helper: length of the current clock-low stretch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_cnt_r <= 9'h000;
    end else begin
      low_cnt_r <= scl_low_r ? low_cnt_r + 9'h001 : 9'h000;
    end
  end

  AST_DATA_CHANGES_LOW: assert property (@(posedge clk_sys) disable iff (rst)
    ($changed(sda_low_r) && !scl_low_r) |-> (is_start || is_stop))
    else $error("data line moved during clock high outside start or stop");

  AST_START_SHAPE: assert property (@(posedge clk_sys) disable iff (rst)
    ($rose(sda_low_r) && !scl_low_r) |-> is_start)
    else $error("data fell under clock high without a start command");

  AST_STOP_SHAPE: assert property (@(posedge clk_sys) disable iff (rst)
    ($fell(sda_low_r) && !scl_low_r) |-> is_stop)
    else $error("data rose under clock high without a stop command");

  AST_CLOCK_LOW_TIME: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(scl_low_r) |-> (low_cnt_r >= T_LOW_CYC - 9'h001))
    else $error("clock low phase shorter than minimum");

  AST_IDLE_BEFORE_START: assert property (@(posedge clk_sys) disable iff (rst)
    (accept && bif.cmd == TSIP_CMD_START && !in_xfer_r) |-> bus_free)
    else $error("start issued onto a busy bus");

endmodule

//--- hw/tsip_host_ctrl.sv
// transaction sequencer for reading and writing the temperature sensor registers
`timescale 1ns/100ps
// Functional notes
// - device is slave only; this master makes the clock and runs transfers.
// - every unit is eight data bits then one acknowledge bit.
// - master clocks out every byte of a 16-bit register without gaps.
// - data falling while clock high is a START.
// - data rising while clock high is a STOP.
// - data changes only while clock is low.
// - master starts only when both lines are high.
// - each transfer opens with START, closes with STOP, bytes acknowledged.
// - receiver acknowledges by holding data low through the ninth clock high.
// - master receiver refuses acknowledge on the last byte, then STOP.
// - a read may reuse the held pointer, else write it first.
module tsip_host_ctrl (
  // system
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  // user request
  input  wire logic                             req,
  input  wire logic                             op_read,
  input  wire logic                             set_ptr,
  input  wire logic [tsip_pkg::PTR_W-1:0]       ptr_sel,
  input  wire logic [15:0]                      wdata,
  input  wire logic [tsip_pkg::ADDR_SEL_W-1:0]  addr_sel,
  // user answer
  output logic                                  busy,
  output logic                                  done,
  output logic                                  nack_err,
  output logic [15:0]                           rdata,
  // clock line
  input  wire logic                             scl_i,
  output logic                                  scl_o,
  output logic                                  scl_oe,
  // data line
  input  wire logic                             sda_i,
  output logic                                  sda_o,
  output logic                                  sda_oe
);
  import tsip_pkg::*;

  tsip_bit_if bif ();

  tsip_bit_engine u_engine (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bif     (bif),
    .scl_i   (scl_i),
    .scl_o   (scl_o),
    .scl_oe  (scl_oe),
    .sda_i   (sda_i),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe)
  );

  tsip_state_type        state_r;
  tsip_stage_type        stage_r;
  logic                  wait_r;
  logic [3:0]            bit_cnt_r;
  logic [7:0]            sh_r;
  logic [1:0]            left_r;
  logic                  op_read_r;
  logic [PTR_W-1:0]      ptr_r;
  logic [15:0]           wdata_r;
  logic [ADDR_SEL_W-1:0] addr_sel_r;
  logic [15:0]           rdata_r;
  logic                  nack_r;
  logic                  done_r;

  // address byte: fixed high nibble, strap bits, direction
  wire [7:0] addr_byte_w = {ADDR_FIXED, addr_sel_r, 1'b0};
  wire [7:0] addr_byte_r = {ADDR_FIXED, addr_sel_r, 1'b1};
  wire [7:0] ptr_byte    = {PTR_PAD, ptr_r};
  wire       data_phase  = (bit_cnt_r != BIT_ACK);
  wire       tx_state    = (state_r == S_TX);
  // a short read would desync the device, so lengths follow the register width
  wire [1:0] rd_len      = (ptr_r == PTR_CONFIGURATION_BYTE) ? LEN_ONE : LEN_TWO;
  // writes aimed at the read-only result stop after the pointer byte
  wire [1:0] wr_len      = (ptr_r == PTR_TEMP) ? LEN_NONE : rd_len;
  wire [7:0] wr_first    = (wr_len == LEN_TWO) ? wdata_r[15:8] : wdata_r[7:0];
  wire       last_rx     = (left_r == LEN_ONE);

  assign bif.cmd_valid = (state_r != S_IDLE) & ~wait_r;
  assign bif.cmd = (state_r == S_START) ? TSIP_CMD_START :
                   (state_r == S_STOP)  ? TSIP_CMD_STOP  :
                   (tx_state == data_phase) ? TSIP_CMD_WRITE : TSIP_CMD_READ;
  // transmit MSB first; in receive the ninth bit is ack low, or high on the last byte
  assign bif.wbit = tx_state ? sh_r[7] : last_rx;

  assign busy     = (state_r != S_IDLE);
  assign done     = done_r;
  assign nack_err = nack_r;
  assign rdata    = rdata_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b0;
    end else if (bif.cmd_valid && bif.cmd_ready) begin
      wait_r <= 1'b1;
    end else if (bif.done) begin
      wait_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r    <= S_IDLE;
      stage_r    <= STG_ADDR_W;
      bit_cnt_r  <= 4'h0;
      sh_r       <= 8'h00;
      left_r     <= LEN_NONE;
      op_read_r  <= 1'b0;
      ptr_r      <= PTR_RESET;
      wdata_r    <= 16'h0000;
      addr_sel_r <= 3'h0;
      rdata_r    <= 16'h0000;
      nack_r     <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (state_r == S_IDLE && req) begin
        op_read_r  <= op_read;
        wdata_r    <= wdata;
        addr_sel_r <= addr_sel;
        nack_r     <= 1'b0;
        rdata_r    <= 16'h0000;
        state_r    <= S_START;
        if (set_ptr || !op_read) begin
          ptr_r   <= ptr_sel;
          stage_r <= STG_ADDR_W;
        end else begin
          stage_r <= STG_ADDR_R; // held pointer is reused
        end
      end else if (wait_r && bif.done) begin
        unique case (state_r)
          S_START: begin
            state_r   <= S_TX;
            bit_cnt_r <= 4'h0;
            sh_r      <= (stage_r == STG_ADDR_R) ? addr_byte_r : addr_byte_w;
          end
          S_TX: begin
            bit_cnt_r <= data_phase ? bit_cnt_r + 4'h1 : 4'h0;
            if (data_phase) begin
              sh_r <= {sh_r[6:0], 1'b0};
            end else if (bif.rbit) begin
              nack_r  <= 1'b1;
              state_r <= S_STOP;
            end else begin
              unique case (stage_r)
                STG_ADDR_W: begin
                  stage_r <= STG_PTR;
                  sh_r    <= ptr_byte;
                end
                STG_PTR: begin
                  // pointer set then repeated start for the read
                  stage_r <= op_read_r ? STG_ADDR_R : STG_WDATA;
                  state_r <= op_read_r ? S_START : ((wr_len == LEN_NONE) ? S_STOP : S_TX);
                  left_r  <= wr_len;
                  sh_r    <= wr_first;
                end
                STG_WDATA: begin
                  state_r <= (left_r == LEN_ONE) ? S_STOP : S_TX;
                  left_r  <= left_r - 2'h1;
                  sh_r    <= wdata_r[7:0];
                end
                default: begin
                  stage_r <= STG_RDATA;
                  state_r <= S_RX;
                  left_r  <= rd_len;
                end
              endcase
            end
          end
          S_RX: begin
            bit_cnt_r <= data_phase ? bit_cnt_r + 4'h1 : 4'h0;
            if (data_phase) begin
              rdata_r <= {rdata_r[14:0], bif.rbit};
            end else begin
              left_r  <= left_r - 2'h1;
              state_r <= last_rx ? S_STOP : S_RX;
            end
          end
          default: begin
            state_r <= S_IDLE;
            done_r  <= 1'b1;
          end
        endcase
      end
    end
  end

  sequence stop_done_seq;
    (state_r == S_STOP) && wait_r && bif.done;
  endsequence

  sequence read_entry_seq;
    (state_r == S_TX) && (stage_r == STG_ADDR_R) && !data_phase && wait_r && bif.done && !bif.rbit;
  endsequence

  AST_NINTH_BIT_IS_ACK: assert property (@(posedge clk_sys) disable iff (rst)
    (tx_state && !data_phase && bif.cmd_valid) |-> (bif.cmd == TSIP_CMD_READ))
    else $error("ninth bit of a sent byte is not an acknowledge read");

  AST_NACK_LAST_BYTE: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == S_RX && !data_phase && last_rx && bif.cmd_valid) |-> (bif.cmd == TSIP_CMD_WRITE && bif.wbit))
    else $error("last received byte was acknowledged");

  AST_ACK_MORE_BYTES: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == S_RX && !data_phase && !last_rx && bif.cmd_valid) |-> !bif.wbit)
    else $error("intermediate received byte was not acknowledged");

  AST_STOP_ENDS_TRANSFER: assert property (@(posedge clk_sys) disable iff (rst)
    stop_done_seq |=> (done && state_r == S_IDLE) ##1 !done)
    else $error("stop did not close the transfer with a single done pulse");

  AST_READ_LENGTH: assert property (@(posedge clk_sys) disable iff (rst)
    read_entry_seq |=> (state_r == S_RX) && (left_r == ((ptr_r == PTR_CONFIGURATION_BYTE) ? LEN_ONE : LEN_TWO)))
    else $error("read length does not match register width");

  AST_ADDRESS_PREFIX: assert property (@(posedge clk_sys) disable iff (rst)
    ((state_r == S_START) && wait_r && bif.done) |=> (sh_r[7:4] == ADDR_FIXED))
    else $error("address byte lacks the fixed prefix");

endmodule

//--- verification/tsip_dev_model.sv
// behavioural two-wire temperature sensor answering the host controller
`timescale 1ns/100ps
module tsip_dev_model #(
  parameter logic [2:0]  ADDR_PINS = 3'h5,
  parameter logic [15:0] TEMP_VAL  = 16'h1980
) (
  // bus lines
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_drv,
  // bench control
  input  wire logic slow
);
  import tsip_pkg::*;
  logic [7:0]  configuration_byte_r = CONFIGURATION_BYTE_RESET;
  logic [15:0] hyst_r = HYST_RESET;
  logic [15:0] trip_r = TRIP_RESET;
  logic [1:0]  ptr_r  = PTR_RESET;
  logic        pend   = 1'b0;
  initial sda_drv = 1'b0;
  // no clock output at all: slave only

  function automatic logic [15:0] reg_val(input logic [1:0] p);
    case (p)
      PTR_TEMP: reg_val = TEMP_VAL;
      PTR_CONFIGURATION_BYTE: reg_val = {configuration_byte_r, 8'h00};
      PTR_HYST: reg_val = hyst_r;
      default:  reg_val = trip_r;
    endcase
  endfunction

  // slow answers still land well inside the low phase
  task automatic put(input logic v);
    if (slow) #400;
    sda_drv = v;
  endtask

  task automatic wait_edge(input logic rising);
    do begin
      if (rising) @(posedge sda);
      else @(negedge sda);
    end while (scl !== 1'b1);
  endtask

  task automatic rx_byte(output logic [7:0] b);
    repeat (8) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    @(negedge scl);
  endtask

  // keep: hold low so a read byte follows without a glitch
  task automatic ack(input logic keep);
    put(1'b1);
    @(negedge scl);
    if (!keep) sda_drv = 1'b0;
  endtask

  task automatic tx_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      put(~b[i]);
      @(posedge scl);
      @(negedge scl);
    end
    sda_drv = 1'b0;
    @(posedge scl);
    nack = sda;
    @(negedge scl);
  endtask

  task automatic run();
    logic [7:0]  b;
    logic [7:0]  hb;
    logic [15:0] v;
    logic        nk;
    int          n;
    rx_byte(b);
    if (b[7:1] !== {ADDR_FIXED, ADDR_PINS}) return;
    ack(b[0]);
    if (b[0]) begin
      v = reg_val(ptr_r);
      nk = 1'b0;
      while (!nk) begin
        tx_byte(v[15:8], nk);
        v = {v[7:0], v[15:8]};
      end
    end else begin
      rx_byte(b);
      ptr_r = b[1:0];
      ack(1'b0);
      n = 0;
      forever begin
        rx_byte(b);
        n++;
        if (ptr_r == PTR_CONFIGURATION_BYTE) configuration_byte_r = b;
        else if (n == 2 && ptr_r == PTR_HYST) hyst_r = {hb, b};
        else if (n == 2 && ptr_r == PTR_TRIP) trip_r = {hb, b};
        hb = b;
        ack(1'b0);
      end
    end
  endtask

  initial begin
    forever begin
      if (!pend) wait_edge(1'b0);
      pend = 1'b0;
      fork
        run();
        wait_edge(1'b1);
        begin
          wait_edge(1'b0);
          pend = 1'b1;
        end
      join_any
      disable fork;
      sda_drv = 1'b0;
    end
  end
endmodule

//--- verification/tsip_host_ctrl_tb.sv
// self-checking bench for the temperature sensor host controller
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %0t: got %h exp %h", $time, (got), (exp)); end end
module tsip_host_ctrl_tb;
  import tsip_pkg::*;
  localparam logic [2:0]  DEV_ADDR = 3'h5;
  localparam logic [15:0] TEMP_VAL = 16'h1980;  // arbitrary reading
  localparam logic [3:0][15:0] DFLT = {TRIP_RESET, HYST_RESET, {8'h00, CONFIGURATION_BYTE_RESET}, TEMP_VAL};
  logic        clk_sys  = 1'b0;
  logic        rst      = 1'b1;
  logic        req      = 1'b0;
  logic        op_read  = 1'b0;
  logic        set_ptr  = 1'b0;
  logic [1:0]  ptr_sel  = 2'h0;
  logic [15:0] wdata    = 16'h0000;
  logic [2:0]  addr_sel = 3'h0;
  logic        slow     = 1'b0;
  logic        busy, done, nack_err, scl_o, scl_oe, sda_o, sda_oe, dev_sda;
  logic [15:0] rdata;
  wire logic   scl_line = ~scl_oe;
  wire logic   sda_line = ~(sda_oe | dev_sda);
  int          mismatches = 0;
  int          n_compared = 0;
  int          n_rise = 0;
  int          cyc = 0;

  always #4 clk_sys = ~clk_sys;
  always @(posedge scl_line) n_rise++;

  tsip_host_ctrl tsip_host_ctrl_i (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .req      (req),
    .op_read  (op_read),
    .set_ptr  (set_ptr),
    .ptr_sel  (ptr_sel),
    .wdata    (wdata),
    .addr_sel (addr_sel),
    .busy     (busy),
    .done     (done),
    .nack_err (nack_err),
    .rdata    (rdata),
    .scl_i    (scl_line),
    .scl_o    (scl_o),
    .scl_oe   (scl_oe),
    .sda_i    (sda_line),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe)
  );

  tsip_dev_model #(.ADDR_PINS(DEV_ADDR), .TEMP_VAL(TEMP_VAL)) tsip_dev_model_i (
    .scl     (scl_line),
    .sda     (sda_line),
    .sda_drv (dev_sda),
    .slow    (slow)
  );

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one whole transaction; nbytes counts every byte framed on the wire
  task automatic xfer(input logic rd, input logic sp, input logic [1:0] p, input logic [15:0] wd,
                      input logic [2:0] as, input int nbytes);
    int k;
    @(posedge clk_sys);
    #1;
    n_rise = 0;
    req = 1'b1;
    op_read = rd;
    set_ptr = sp;
    ptr_sel = p;
    wdata = wd;
    addr_sel = as;
    @(posedge clk_sys);
    #1;
    req = 1'b0;
    `CHK(busy, 1'b1)
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k == 20000) mismatches++;
    `CHK(busy, 1'b0)
    `CHK(n_rise, 9 * nbytes + ((rd && sp) ? 2 : 1) + 1)
  endtask

  // hang guard sized a little above the whole sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 104000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    `CHK(scl_oe, 1'b0)
    `CHK(sda_oe, 1'b0)
    `CHK(scl_o, 1'b0)
    `CHK(sda_o, 1'b0)
    `CHK(rdata, 16'h0000)
    xfer(1'b1, 1'b0, PTR_TEMP, 16'h0000, DEV_ADDR, 3);
    `CHK(rdata, TEMP_VAL)
    for (int i = 1; i < 4; i++) begin
      xfer(1'b1, 1'b1, 2'(i), 16'h0000, DEV_ADDR, (i == 1) ? 4 : 5);
      `CHK(rdata, DFLT[i])
      `CHK(nack_err, 1'b0)
    end
    // trip written, then read back on the held pointer with a slow device
    xfer(1'b0, 1'b0, PTR_TRIP, 16'h1234, DEV_ADDR, 4);
    slow = 1'b1;
    xfer(1'b1, 1'b0, PTR_TRIP, 16'h0000, DEV_ADDR, 3);
    slow = 1'b0;
    `CHK(rdata, 16'h1234)
    xfer(1'b0, 1'b0, PTR_TEMP, 16'hffff, DEV_ADDR, 2);
    xfer(1'b1, 1'b0, PTR_TEMP, 16'h0000, DEV_ADDR, 3);
    `CHK(rdata, TEMP_VAL)
    xfer(1'b1, 1'b0, PTR_TEMP, 16'h0000, ~DEV_ADDR, 1);
    `CHK(nack_err, 1'b1)
    end_of_test();
  end
endmodule
